// ---- rrcr_top.sv ----
// Receiver configuration register bank with frame acceptance logic
`timescale 1ns/1ns
module rrcr_top (
  input  wire logic                   clk_sys_i,     // System clock
  input  wire logic                   rst_i,         // Async reset, active high
  input  wire logic [7:0]             addr_i,        // Register address
  input  wire logic [7:0]             wdata_i,       // Write data
  input  wire logic                   wr_i,          // Write strobe
  input  wire logic                   rd_i,          // Read strobe
  output logic [7:0]                  rdata_o,       // Read data, cycle after rd_i
  input  wire rrcr_pkg::rrcr_rxin_t   rxin_i,        // Receiver front events
  input  wire logic                   crc_enable_i,  // Checksum checking on
  input  wire logic [7:0]             error_reg_i,   // Current error register
  input  wire logic                   tx_end_i,      // End of sending pulse
  output rrcr_pkg::rrcr_fifo_t        fifo_o,        // FIFO write and reset
  output logic                        frame_start_event_o, // Frame-start or subcarrier-rise event
  output logic                        rx_complete_o, // Receive complete event
  output logic                        rx_stop_o,     // Terminate reception
  output logic                        guard_active_o,// Inputs being ignored
  output logic                        baud_valid_o,  // Baud code is defined
  output rrcr_pkg::rrcr_ctrl_t        rx_control_o,  // Receive control fields
  output rrcr_pkg::rrcr_thresh_t      threshold_o,   // Decoder thresholds
  output rrcr_pkg::rrcr_rcv_t         rcv_o          // Input select fields
);
  import rrcr_pkg::*;

  // ****************************************************************
  // Decoding and register storage
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  typedef enum {ST_IDLE, ST_RECV} rrcr_state_t;

  rrcr_sofd_t   sofd;
  rrcr_guard_t  guard;
  rrcr_sofd_t   next_sofd;
  rrcr_ctrl_t   next_ctrl;
  rrcr_guard_t  next_guard;
  rrcr_thresh_t next_thresh;
  rrcr_rcv_t    next_rcv;
  logic [7:0]   next_rdata;
  rrcr_sofd_t   wsofd;
  rrcr_ctrl_t   wctrl;
  rrcr_rcv_t    wrcv;
  logic         sof_clr;
  logic         subc_clr;

  assign wsofd = rrcr_sofd_t'(wdata_i);
  assign wctrl = rrcr_ctrl_t'(wdata_i);
  assign wrcv  = rrcr_rcv_t'(wdata_i);
  assign sof_clr  = wr_i && hit(addr_i, OFS_FRAME_START_DETECT) && !wsofd.frame_start_seen;
  assign subc_clr = wr_i && hit(addr_i, OFS_FRAME_START_DETECT) && !wsofd.subcarrier_seen;

  // ****************************************************************
  // Gated receiver inputs
  // ****************************************************************
  logic sof_in;
  logic subc_in;
  logic byte_in;
  logic end_in;
  logic err_in;
  logic subc_rise;

  // Inputs during the guard window are dropped, not delayed
  assign sof_in    = rxin_i.sof && !guard_active_o;
  assign subc_in   = rxin_i.subc && !guard_active_o;
  assign byte_in   = rxin_i.byte_valid && !guard_active_o;
  assign end_in    = rxin_i.frame_end && !guard_active_o;
  // Collisions only count while detection is switched on
  assign err_in    = rxin_i.error ||
                     (rxin_i.coll && rcv_o.collision_threshold != COLL_OFF);
  assign subc_rise = subc_in && !sofd.subcarrier_now;

  always_comb begin
    next_sofd   = sofd;
    next_ctrl   = rx_control_o;
    next_guard  = guard;
    next_thresh = threshold_o;
    next_rcv    = rcv_o;
    next_rdata  = 8'h00;
    if (wr_i) begin
      if (hit(addr_i, OFS_FRAME_START_DETECT)) begin
        next_sofd.frame_start_event_enable = wsofd.frame_start_event_enable;
        next_sofd.subcarrier_event_enable  = wsofd.subcarrier_event_enable;
      end
      if (hit(addr_i, OFS_RX_CONTROL)) begin
        next_ctrl      = wctrl;
        next_ctrl.rsvd = '0;
      end
      if (hit(addr_i, OFS_RX_GUARD_TIME)) begin
        next_guard = rrcr_guard_t'(wdata_i);
      end
      if (hit(addr_i, OFS_RX_DECODER_THRESH)) begin
        next_thresh = rrcr_thresh_t'(wdata_i);
      end
      if (hit(addr_i, OFS_RECEIVER_INPUT_SEL)) begin
        next_rcv      = wrcv;
        next_rcv.rsvd = '0;
      end
    end
    // A detection in the clearing cycle wins over the clear
    if (sof_clr) begin
      next_sofd.frame_start_seen = 1'b0;
    end
    if (sof_in) begin
      next_sofd.frame_start_seen = 1'b1;
    end
    if (subc_clr) begin
      next_sofd.subcarrier_seen = 1'b0;
    end
    if (subc_in) begin
      next_sofd.subcarrier_seen = 1'b1;
    end
    next_sofd.subcarrier_now = subc_in;
    next_sofd.rsvd_hi        = '0;
    next_sofd.rsvd_mid       = 1'b0;
    if (rd_i) begin
      if (hit(addr_i, OFS_FRAME_START_DETECT)) begin
        next_rdata = sofd;
      end else if (hit(addr_i, OFS_RX_CONTROL)) begin
        next_rdata = rx_control_o;
      end else if (hit(addr_i, OFS_RX_GUARD_TIME)) begin
        next_rdata = guard;
      end else if (hit(addr_i, OFS_RX_DECODER_THRESH)) begin
        next_rdata = threshold_o;
      end else if (hit(addr_i, OFS_RECEIVER_INPUT_SEL)) begin
        next_rdata = rcv_o;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sofd         <= rrcr_sofd_t'(SOFD_RST);
      rx_control_o <= rrcr_ctrl_t'(CTRL_RST);
      guard        <= rrcr_guard_t'(GUARD_RST);
      threshold_o  <= rrcr_thresh_t'(THRESH_RST);
      rcv_o        <= rrcr_rcv_t'(RCV_RST);
      rdata_o      <= 8'h00;
    end else begin
      sofd         <= next_sofd;
      rx_control_o <= next_ctrl;
      guard        <= next_guard;
      threshold_o  <= next_thresh;
      rcv_o        <= next_rcv;
      rdata_o      <= next_rdata;
    end
  end

  // ****************************************************************
  // Frame acceptance
  // ****************************************************************
  rrcr_state_t state;
  rrcr_state_t next_state;
  logic [1:0]  byte_cnt;
  logic [1:0]  next_byte_cnt;
  rrcr_fifo_t  next_fifo;
  logic        next_fs_event;
  logic        next_complete;
  logic        next_stop;
  logic        next_baud_valid;
  logic        early;
  logic        drop_partial;

  assign early = rx_control_o.disturbance_suppress && byte_cnt < EMD_BYTES;
  // Without the allow bit an incomplete byte is lost when the checksum is checked
  assign drop_partial = rxin_i.partial && crc_enable_i &&
                        !rx_control_o.allow_partial_bytes;

  always_comb begin
    next_state      = state;
    next_byte_cnt   = byte_cnt;
    next_fifo       = '0;
    next_complete   = 1'b0;
    next_stop       = 1'b0;
    next_fs_event   = (sof_in && sofd.frame_start_event_enable) ||
                      (subc_rise && sofd.subcarrier_event_enable);
    next_baud_valid = rx_control_o.baud_rate == BAUD_26K ||
                      rx_control_o.baud_rate == BAUD_52K;
    case (state)
      ST_IDLE: begin
        if (sof_in) begin
          next_state    = ST_RECV;
          next_byte_cnt = 2'h0;
        end
      end
      ST_RECV: begin
        if (end_in) begin
          if (early) begin
            next_fifo.rst = 1'b1;
          end else begin
            next_complete = 1'b1;
            if (rx_control_o.multi_frame_receive) begin
              next_fifo.wr   = 1'b1;
              next_fifo.data = error_reg_i;
            end
          end
          // A multi-frame receiver stays armed for the next frame start
          next_stop  = !rx_control_o.multi_frame_receive;
          next_state = ST_IDLE;
        end else if (byte_in) begin
          if (early && err_in) begin
            next_fifo.rst = 1'b1;
            next_byte_cnt = 2'h0;
          end else if (!drop_partial) begin
            next_fifo.wr   = 1'b1;
            next_fifo.data = rxin_i.data;
            if (byte_cnt != EMD_BYTES) begin
              next_byte_cnt = byte_cnt + 2'h1;
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state               <= ST_IDLE;
      byte_cnt            <= 2'h0;
      fifo_o              <= '0;
      frame_start_event_o <= 1'b0;
      rx_complete_o       <= 1'b0;
      rx_stop_o           <= 1'b0;
      baud_valid_o        <= 1'b0;
    end else begin
      state               <= next_state;
      byte_cnt            <= next_byte_cnt;
      fifo_o              <= next_fifo;
      frame_start_event_o <= next_fs_event;
      rx_complete_o       <= next_complete;
      rx_stop_o           <= next_stop;
      baud_valid_o        <= next_baud_valid;
    end
  end

  rrcr_guard_timer u_guard (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .start_i   (tx_end_i),
    .count_i   (guard.guard_count),
    .unit_i    (guard.rx_guard_unit_select),
    .baud_i    (rx_control_o.baud_rate),
    .active_o  (guard_active_o)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  rrcr_ctrl_t rd_ctrl;
  assign rd_ctrl = rrcr_ctrl_t'(rdata_o);

  a_sof_event_raise: assert property (
    rxin_i.sof && !guard_active_o && sofd.frame_start_event_enable |=> frame_start_event_o)
    else $error("frame start event missing");
  a_sof_seen_hold: assert property (
    sofd.frame_start_seen && !sof_clr |=> sofd.frame_start_seen)
    else $error("frame start seen bit lost");
  a_subc_seen_hold: assert property (
    sofd.subcarrier_seen && !subc_clr |=> sofd.subcarrier_seen)
    else $error("subcarrier seen bit lost");
  a_subc_now_live: assert property (
    rxin_i.subc && !guard_active_o |=> sofd.subcarrier_now ##0 sofd.subcarrier_seen)
    else $error("live subcarrier bit wrong");
  a_partial_drop_rule: assert property (
    state == ST_RECV && byte_in && !end_in && !early && drop_partial |=> !fifo_o.wr)
    else $error("partial byte written");
  a_error_byte_add: assert property (
    state == ST_RECV && end_in && !early && rx_control_o.multi_frame_receive
    |=> fifo_o.wr && fifo_o.data == $past(error_reg_i) && !rx_stop_o)
    else $error("error byte not appended");
  a_emd_short_frame: assert property (
    state == ST_RECV && end_in && early |=> fifo_o.rst && !rx_complete_o)
    else $error("short frame not suppressed");
  a_guard_blanks_sof: assert property (
    guard_active_o && !sofd.frame_start_seen |=> !sofd.frame_start_seen)
    else $error("input seen during guard");
  a_reserved_read_zero: assert property (
    rd_i && hit(addr_i, OFS_RX_CONTROL) |=> rd_ctrl.rsvd == 2'h0)
    else $error("reserved bits not zero");

  c_multi_frame: cover property (
    state == ST_RECV && end_in && rx_control_o.multi_frame_receive ##[1:200] sof_in);
  c_emd_discard: cover property (state == ST_RECV && byte_in && early && err_in);
  c_guard_then_sof: cover property ($fell(guard_active_o) ##[1:50] frame_start_event_o);

endmodule

// ---- rrcr_pkg.sv ----
// Package with register map, field layouts and timing constants of the receiver config bank
package rrcr_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_FRAME_START_DETECT = 8'h34;
  localparam logic [7:0] OFS_RX_CONTROL         = 8'h35;
  localparam logic [7:0] OFS_RX_GUARD_TIME      = 8'h36;
  localparam logic [7:0] OFS_RX_DECODER_THRESH  = 8'h37;
  localparam logic [7:0] OFS_RECEIVER_INPUT_SEL = 8'h38;

  // ****************************************************************
  // Register layouts, most significant field first
  // ****************************************************************
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       frame_start_event_enable;
    logic       frame_start_seen;
    logic       rsvd_mid;
    logic       subcarrier_event_enable;
    logic       subcarrier_seen;
    logic       subcarrier_now;
  } rrcr_sofd_t;

  typedef struct packed {
    logic       allow_partial_bytes;
    logic       multi_frame_receive;
    logic [1:0] rsvd;
    logic       disturbance_suppress;
    logic [2:0] baud_rate;
  } rrcr_ctrl_t;

  typedef struct packed {
    logic       rx_guard_unit_select;
    logic [6:0] guard_count;
  } rrcr_guard_t;

  typedef struct packed {
    logic [3:0] decoder_min_level;
    logic [3:0] phase_min_level;
  } rrcr_thresh_t;

  typedef struct packed {
    logic       single_input_mode;
    logic       converter_mode_select;
    logic [1:0] signal_source_select;
    logic [1:0] rsvd;
    logic [1:0] collision_threshold;
  } rrcr_rcv_t;

  // Receiver front events, all synchronous to clk_sys_i
  typedef struct packed {
    logic       sof;
    logic       subc;
    logic       byte_valid;
    logic [7:0] data;
    logic       partial;
    logic       error;
    logic       coll;
    logic       frame_end;
  } rrcr_rxin_t;

  typedef struct packed {
    logic       wr;
    logic       rst;
    logic [7:0] data;
  } rrcr_fifo_t;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [2:0] BAUD_26K     = 3'h2;
  localparam logic [2:0] BAUD_52K     = 3'h3;
  localparam logic [1:0] COLL_OFF     = 2'h3;
  localparam logic [1:0] EMD_BYTES    = 2'h3;
  localparam logic [7:0] SOFD_RST     = 8'h00;
  localparam logic [7:0] CTRL_RST     = 8'h02;
  localparam logic [7:0] GUARD_RST    = 8'h00;
  localparam logic [7:0] THRESH_RST   = 8'h00;
  localparam logic [7:0] RCV_RST      = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_KHZ   = 100000;
  localparam int CARRIER_KHZ    = 13560;
  localparam int GUARD_CARRIERS = 16;
  localparam int BAUD26_KBD     = 26;
  localparam int BAUD52_KBD     = 52;
  localparam int UNIT_W         = 11;
  // Guard units round down: the guard is a longest ignore window
  localparam logic [UNIT_W-1:0] UNIT_CARRIER_CYC =
    UNIT_W'(GUARD_CARRIERS * CLK_FREQ_KHZ / CARRIER_KHZ);
  localparam logic [UNIT_W-1:0] UNIT_HALF26_CYC = UNIT_W'(CLK_FREQ_KHZ / (2 * BAUD26_KBD));
  localparam logic [UNIT_W-1:0] UNIT_HALF52_CYC = UNIT_W'(CLK_FREQ_KHZ / (2 * BAUD52_KBD));

endpackage

// ---- rrcr_guard_timer.sv ----
// Post-transmit guard timer that blanks receiver inputs
`timescale 1ns/1ns
module rrcr_guard_timer (
  input  wire logic       clk_sys_i,  // System clock
  input  wire logic       rst_i,      // Async reset, active high
  input  wire logic       start_i,    // End of sending pulse
  input  wire logic [6:0] count_i,    // Guard count in units
  input  wire logic       unit_i,     // 0 carrier unit, 1 half bit
  input  wire logic [2:0] baud_i,     // Receive baud code
  output logic            active_o    // Inputs ignored while high
);
  import rrcr_pkg::*;

  logic [6:0]        remain;
  logic [UNIT_W-1:0] pre;
  logic [6:0]        next_remain;
  logic [UNIT_W-1:0] next_pre;
  logic              next_active;
  logic [UNIT_W-1:0] unit_len;

  always_comb begin
    if (!unit_i) begin
      unit_len = UNIT_CARRIER_CYC;
    end else if (baud_i == BAUD_52K) begin
      unit_len = UNIT_HALF52_CYC;
    end else begin
      unit_len = UNIT_HALF26_CYC;
    end
  end

  always_comb begin
    next_remain = remain;
    next_pre    = pre;
    next_active = active_o;
    if (start_i && count_i != 7'h00) begin
      next_remain = count_i;
      next_pre    = unit_len - UNIT_W'(1);
      next_active = 1'b1;
    end else if (active_o) begin
      if (pre != '0) begin
        next_pre = pre - UNIT_W'(1);
      end else if (remain == 7'h01) begin
        next_active = 1'b0;
      end else begin
        next_remain = remain - 7'h01;
        next_pre    = unit_len - UNIT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      remain   <= '0;
      pre      <= '0;
      active_o <= 1'b0;
    end else begin
      remain   <= next_remain;
      pre      <= next_pre;
      active_o <= next_active;
    end
  end

  a_guard_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_i && count_i != 7'h00 |=> active_o [*2])
    else $error("guard window did not open");

endmodule

// ---- rrcr_tag_model.sv ----
// Behavioural model of the tag side feeding receiver front events
`timescale 1ns/1ns
module rrcr_tag_model (
  input  wire logic           clk_sys_i, // System clock
  output rrcr_pkg::rrcr_rxin_t rxin_o    // Events toward the bank
);
  import rrcr_pkg::*;

  initial begin
    rxin_o = '0;
  end

  // One event cycle; afterwards the data lines show the inverse so a stale byte never
  // looks like a held value, while the subcarrier level stays as commanded
  task automatic ev(input rrcr_rxin_t v);
    @(posedge clk_sys_i);
    rxin_o <= v;
    @(posedge clk_sys_i);
    rxin_o <= '{subc: v.subc, data: ~v.data, default: '0};
  endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the receiver configuration register bank
`timescale 1ns/1ns
module tb;
  import rrcr_pkg::*;
  logic         clk_sys_i;
  logic         rst_i;
  logic         wr_i;
  logic         rd_i;
  logic         crc_enable_i;
  logic         tx_end_i;
  logic [7:0]   addr_i;
  logic [7:0]   wdata_i;
  logic [7:0]   rdata_o;
  logic [7:0]   error_reg_i;
  rrcr_rxin_t   rxin;
  rrcr_fifo_t   fifo_o;
  logic         fse;
  logic         rxc;
  logic         rxs;
  logic         grd;
  logic         bv;
  rrcr_ctrl_t   ctrl_o;
  rrcr_thresh_t thr_o;
  rrcr_rcv_t    rcv_o;
  int           fails;
  int           tests_run;
  logic [7:0]   ofs [5] = '{OFS_FRAME_START_DETECT, OFS_RX_CONTROL, OFS_RX_GUARD_TIME,
                            OFS_RX_DECODER_THRESH, OFS_RECEIVER_INPUT_SEL};
  logic [7:0]   rstv [5] = '{SOFD_RST, CTRL_RST, GUARD_RST, THRESH_RST, RCV_RST};
  logic [7:0]   msk [5] = '{8'h24, 8'hCF, 8'hFF, 8'hFF, 8'hF3};

  rrcr_top u_rrcr_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxin_i(rxin),
    .crc_enable_i(crc_enable_i), .error_reg_i(error_reg_i), .tx_end_i(tx_end_i),
    .fifo_o(fifo_o), .frame_start_event_o(fse), .rx_complete_o(rxc), .rx_stop_o(rxs),
    .guard_active_o(grd), .baud_valid_o(bv), .rx_control_o(ctrl_o),
    .threshold_o(thr_o), .rcv_o(rcv_o));
  rrcr_tag_model u_rrcr_tag_model (.clk_sys_i(clk_sys_i), .rxin_o(rxin));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(16'(rdata_o), 16'(exp));
  endtask

  // Byte with qualifiers {partial, error, coll}; outputs are settled on return
  task automatic byt(input logic [7:0] d, input logic [2:0] q);
    u_rrcr_tag_model.ev('{byte_valid: 1'b1, data: d, partial: q[2], error: q[1],
                          coll: q[0], default: '0});
    #1;
  endtask

  task automatic sof();
    u_rrcr_tag_model.ev('{sof: 1'b1, default: '0});
    #1;
  endtask

  task automatic fend();
    u_rrcr_tag_model.ev('{frame_end: 1'b1, default: '0});
    #1;
  endtask

  task automatic txe();
    @(posedge clk_sys_i);
    tx_end_i <= 1'b1;
    @(posedge clk_sys_i);
    tx_end_i <= 1'b0;
    #1;
  endtask

  // Guard window length in clock cycles, bounded so a stuck window ends the run
  task automatic glen(input logic [7:0] w, input int exp);
    int n;
    n = 0;
    wr(OFS_RX_GUARD_TIME, w);
    txe();
    while (grd === 1'b1 && n < 3000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n == 3000) begin
      fails++;
      finish_test();
    end else begin
      chk(16'(n), 16'(exp));
    end
  endtask

  initial begin
    fails = 0;
    tests_run = 0;
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    crc_enable_i = 1'b0;
    error_reg_i = 8'h5A;
    tx_end_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) rchk(ofs[i], rstv[i]);
    rchk(8'h39, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 8'hFF);
      rchk(ofs[i], msk[i]);
    end
    wr(8'h39, 8'hFF);
    rchk(8'h39, 8'h00);
    chk(16'(rcv_o), 16'h00F3);
    wr(OFS_RX_DECODER_THRESH, 8'hA5);
    chk(16'({thr_o.decoder_min_level, thr_o.phase_min_level}), 16'h00A5);
    for (int b = 0; b < 8; b++) begin
      wr(OFS_RX_CONTROL, 8'(b));
      rchk(OFS_RX_CONTROL, 8'(b));
      chk(16'(bv), 16'(b == 2 || b == 3));
      chk(16'(ctrl_o), 16'(b));
    end
    $display("test register access done");
    wr(OFS_RECEIVER_INPUT_SEL, 8'h00);
    wr(OFS_FRAME_START_DETECT, 8'h20);
    sof();
    chk(16'(fse), 16'h0001);
    rchk(OFS_FRAME_START_DETECT, 8'h30);
    wr(OFS_FRAME_START_DETECT, 8'h00);
    rchk(OFS_FRAME_START_DETECT, 8'h00);
    sof();
    chk(16'(fse), 16'h0000);
    wr(OFS_FRAME_START_DETECT, 8'h04);
    u_rrcr_tag_model.ev('{subc: 1'b1, default: '0});
    #1;
    chk(16'(fse), 16'h0001);
    rchk(OFS_FRAME_START_DETECT, 8'h07);
    u_rrcr_tag_model.ev('{default: '0});
    rchk(OFS_FRAME_START_DETECT, 8'h06);
    wr(OFS_FRAME_START_DETECT, 8'h00);
    rchk(OFS_FRAME_START_DETECT, 8'h00);
    $display("test detection flags done");
    wr(OFS_RX_CONTROL, 8'h4A);
    sof();
    for (int i = 0; i < 3; i++) begin
      byt(8'hA0 + 8'(i), 3'b000);
      chk(16'(fifo_o), 16'h02A0 + 16'(i));
    end
    fend();
    chk(16'(fifo_o), 16'h025A);
    chk(16'({rxc, rxs}), 16'h0002);
    wr(OFS_RX_CONTROL, 8'h0A);
    sof();
    for (int i = 0; i < 3; i++) byt(8'hB0 + 8'(i), 3'b000);
    fend();
    chk(16'({rxc, rxs, fifo_o.wr}), 16'h0006);
    wr(OFS_RX_CONTROL, 8'h4A);
    sof();
    byt(8'hA0, 3'b000);
    byt(8'hA1, 3'b010);
    chk(16'(fifo_o.rst), 16'h0001);
    sof();
    byt(8'hA0, 3'b001);
    chk(16'(fifo_o.rst), 16'h0001);
    wr(OFS_RECEIVER_INPUT_SEL, 8'h03);
    sof();
    byt(8'hA0, 3'b001);
    chk(16'(fifo_o), 16'h02A0);
    sof();
    byt(8'hC0, 3'b000);
    fend();
    chk(16'({fifo_o.rst, rxc}), 16'h0002);
    $display("test frame handling done");
    crc_enable_i <= 1'b1;
    wr(OFS_RX_CONTROL, 8'h02);
    sof();
    byt(8'h3C, 3'b100);
    chk(16'(fifo_o.wr), 16'h0000);
    wr(OFS_RX_CONTROL, 8'h82);
    sof();
    byt(8'h3C, 3'b100);
    chk(16'(fifo_o), 16'h023C);
    crc_enable_i <= 1'b0;
    $display("test partial bytes done");
    glen(8'h01, GUARD_CARRIERS * CLK_FREQ_KHZ / CARRIER_KHZ);
    wr(OFS_RX_CONTROL, 8'h03);
    glen(8'h81, CLK_FREQ_KHZ / (2 * BAUD52_KBD));
    wr(OFS_RX_CONTROL, 8'h02);
    glen(8'h81, CLK_FREQ_KHZ / (2 * BAUD26_KBD));
    wr(OFS_RX_GUARD_TIME, 8'h02);
    wr(OFS_FRAME_START_DETECT, 8'h20);
    txe();
    sof();
    chk(16'(fse), 16'h0000);
    rchk(OFS_FRAME_START_DETECT, 8'h20);
    $display("test guard window done");
    // The FIFO is never read here, so the early-read caution holds trivially
    finish_test();
  end
endmodule
